// [usb_reader_property_map.svh]
// Command codes, property selectors, result codes and default values
`ifndef USB_READER_PROPERTY_MAP_SVH
`define USB_READER_PROPERTY_MAP_SVH
`define CMD_GET      8'h00
`define CMD_SET      8'h01
`define SEL_INTERVAL 8'h02
`define SEL_MAXPKT   8'h03
`define SEL_PERSONA  8'h10
`define RC_OK        8'h00
`define RC_BAD_CMD   8'h01
`define RC_BAD_VAL   8'h02
`define LEN_NONE     8'h00
`define LEN_GET      8'h01
`define LEN_SET      8'h02
`define DEF_INTERVAL 8'h0a
`define DEF_MAXPKT   8'h08
`define DEF_PERSONA  8'h00
`define MIN_VAL      8'h01
`define MAX_MAXPKT   8'h40
`define MAX_PERSONA  8'h01
`define IDX_RC       2'h0
`define IDX_LEN      2'h1
`define IDX_VAL      2'h2
`endif

// [usb_reader_property_pkg.sv]
// Types shared by the property command handler
package usb_reader_property_pkg;
   typedef struct packed
   {
      logic [7:0] interval;
      logic [7:0] max_packet;
      logic [7:0] personality;
   } prop_set_t;

   typedef struct packed
   {
      logic      valid;
      prop_set_t props;
   } nvm_image_t;

   typedef enum logic [2:0] {ST_BOOT, ST_CMD, ST_LEN, ST_DATA, ST_EXEC, ST_RESP} parse_state_t;
endpackage

// [usb_reader_property_config.sv]
// Property command handler with response FIFO and report packetizer
`timescale 1ns/1ps
`include "usb_reader_property_map.svh"

// ****************************************
// Response FIFO
// ****************************************
module prop_rsp_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = mem_reg[rd_ptr_reg];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ****************************************
// Property command handler
// ****************************************
module usb_reader_property_config
#(
   parameter int FIFO_DEPTH = 8
)
(
   input  wire logic                              core_clk_in,
   input  wire logic                              rst_n_in,
   input  wire logic                              cmd_valid_in,
   input  wire logic [7:0]                        cmd_data_in,
   output logic                                   cmd_ready_out,
   output logic                                   rsp_valid_out,
   output logic [7:0]                             rsp_data_out,
   input  wire logic                              rsp_ready_in,
   input  wire usb_reader_property_pkg::nvm_image_t nvm_image_in,
   output logic                                   nvm_wr_out,
   output usb_reader_property_pkg::prop_set_t     nvm_data_out,
   output usb_reader_property_pkg::prop_set_t     desc_cfg_out,
   input  wire logic                              rpt_valid_in,
   input  wire logic [7:0]                        rpt_data_in,
   input  wire logic                              rpt_last_in,
   output logic                                   rpt_ready_out,
   output logic                                   pkt_valid_out,
   output logic [7:0]                             pkt_data_out,
   output logic                                   pkt_end_out,
   input  wire logic                              pkt_ready_in
);
   import usb_reader_property_pkg::*;

   parse_state_t state_reg;
   parse_state_t state_next;
   prop_set_t    stored_reg;
   prop_set_t    active_reg;
   prop_set_t    defaults;
   logic [7:0]   op_reg;
   logic [7:0]   len_reg;
   logic [7:0]   cnt_reg;
   logic [7:0]   sel_reg;
   logic [7:0]   val_reg;
   logic [7:0]   rc_reg;
   logic [7:0]   rlen_reg;
   logic [7:0]   rval_reg;
   logic [1:0]   ridx_reg;
   logic         cmd_ready_reg;
   logic         nvm_wr_reg;
   logic         take;
   logic         known_sel;
   logic         range_ok;
   logic         get_ok;
   logic         set_ok;
   logic [7:0]   sel_value;
   logic         fifo_in_ready;
   logic         fifo_out_valid;
   logic [7:0]   fifo_out_data;
   logic         fifo_pop;
   logic [7:0]   push_data;
   logic         push_last;
   logic         rsp_valid_reg;
   logic [7:0]   rsp_data_reg;

   assign defaults      = '{`DEF_INTERVAL, `DEF_MAXPKT, `DEF_PERSONA};
   assign take          = cmd_valid_in && cmd_ready_reg;
   assign cmd_ready_out = cmd_ready_reg;
   assign nvm_wr_out    = nvm_wr_reg;
   assign nvm_data_out  = stored_reg;
   assign desc_cfg_out  = active_reg;
   assign rsp_valid_out = rsp_valid_reg;
   assign rsp_data_out  = rsp_data_reg;

   // ****************************************
   // Request decode
   // ****************************************
   always_comb
   begin
      known_sel = 1'b1;
      range_ok  = 1'b0;
      sel_value = '0;
      unique case (sel_reg)
         `SEL_INTERVAL:
         begin
            sel_value = stored_reg.interval;
            range_ok  = (val_reg >= `MIN_VAL);
         end
         `SEL_MAXPKT:
         begin
            sel_value = stored_reg.max_packet;
            range_ok  = (val_reg >= `MIN_VAL) && (val_reg <= `MAX_MAXPKT);
         end
         `SEL_PERSONA:
         begin
            sel_value = stored_reg.personality;
            range_ok  = (val_reg <= `MAX_PERSONA);
         end
         default:
         begin
            known_sel = 1'b0;
         end
      endcase
      get_ok = (op_reg == `CMD_GET) && (len_reg == `LEN_GET) && known_sel;
      set_ok = (op_reg == `CMD_SET) && (len_reg == `LEN_SET) && known_sel && range_ok;
   end

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_BOOT: state_next = ST_CMD;
         ST_CMD:  state_next = take ? ST_LEN : ST_CMD;
         ST_LEN:
         begin
            if (take)
            begin
               state_next = (cmd_data_in == `LEN_NONE) ? ST_EXEC : ST_DATA;
            end
         end
         ST_DATA:
         begin
            if (take && (8'(cnt_reg + 8'h01) == len_reg))
            begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: state_next = ST_RESP;
         ST_RESP:
         begin
            if (fifo_in_ready && push_last)
            begin
               state_next = ST_CMD;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg     <= ST_BOOT;
         cmd_ready_reg <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         cmd_ready_reg <= (state_next == ST_CMD) || (state_next == ST_LEN) || (state_next == ST_DATA);
      end
   end

   // Request byte capture
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         op_reg  <= '0;
         len_reg <= '0;
         cnt_reg <= '0;
         sel_reg <= '0;
         val_reg <= '0;
      end
      else if (take)
      begin
         unique case (state_reg)
            ST_CMD: op_reg <= cmd_data_in;
            ST_LEN:
            begin
               len_reg <= cmd_data_in;
               cnt_reg <= '0;
               sel_reg <= '0;
               val_reg <= '0;
            end
            ST_DATA:
            begin
               cnt_reg <= 8'(cnt_reg + 8'h01);
               if (cnt_reg == 8'h00)
               begin
                  sel_reg <= cmd_data_in;
               end
               if (cnt_reg == 8'h01)
               begin
                  val_reg <= cmd_data_in;
               end
            end
            default:
            begin
               op_reg <= op_reg;
            end
         endcase
      end
   end

   // ****************************************
   // Property storage
   // ****************************************
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stored_reg <= '{`DEF_INTERVAL, `DEF_MAXPKT, `DEF_PERSONA};
         active_reg <= '{`DEF_INTERVAL, `DEF_MAXPKT, `DEF_PERSONA};
         nvm_wr_reg <= 1'b0;
      end
      else
      begin
         nvm_wr_reg <= 1'b0;
         if (state_reg == ST_BOOT)
         begin
            stored_reg <= nvm_image_in.valid ? nvm_image_in.props : defaults;
            active_reg <= nvm_image_in.valid ? nvm_image_in.props : defaults;
            nvm_wr_reg <= !nvm_image_in.valid;
         end
         else if ((state_reg == ST_EXEC) && set_ok)
         begin
            unique case (sel_reg)
               `SEL_INTERVAL: stored_reg.interval    <= val_reg;
               `SEL_MAXPKT:   stored_reg.max_packet  <= val_reg;
               default:       stored_reg.personality <= val_reg;
            endcase
            nvm_wr_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Response build
   // ****************************************
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rc_reg   <= `RC_OK;
         rlen_reg <= `LEN_NONE;
         rval_reg <= '0;
         ridx_reg <= `IDX_RC;
      end
      else if (state_reg == ST_EXEC)
      begin
         ridx_reg <= `IDX_RC;
         rval_reg <= sel_value;
         rlen_reg <= get_ok ? `LEN_GET : `LEN_NONE;
         if (get_ok || set_ok)
         begin
            rc_reg <= `RC_OK;
         end
         else if ((op_reg != `CMD_GET) && (op_reg != `CMD_SET))
         begin
            rc_reg <= `RC_BAD_CMD;
         end
         else
         begin
            rc_reg <= `RC_BAD_VAL;
         end
      end
      else if ((state_reg == ST_RESP) && fifo_in_ready)
      begin
         ridx_reg <= 2'(ridx_reg + 2'h1);
      end
   end

   always_comb
   begin
      unique case (ridx_reg)
         `IDX_RC:  push_data = rc_reg;
         `IDX_LEN: push_data = rlen_reg;
         default:  push_data = rval_reg;
      endcase
      push_last = (ridx_reg == `IDX_VAL) || ((ridx_reg == `IDX_LEN) && (rlen_reg == `LEN_NONE));
   end

   prop_rsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rsp_fifo
   (
      .clk_in        (core_clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (state_reg == ST_RESP),
      .in_data_in    (push_data),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out_data),
      .out_ready_in  (fifo_pop)
   );

   assign fifo_pop = !rsp_valid_reg || rsp_ready_in;

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg  <= '0;
      end
      else if (fifo_pop)
      begin
         rsp_valid_reg <= fifo_out_valid;
         rsp_data_reg  <= fifo_out_data;
      end
   end

   // ****************************************
   // Report packetizer
   // ****************************************
   logic       rpt_ready_reg;
   logic       pkt_valid_reg;
   logic [7:0] pkt_data_reg;
   logic       pkt_end_reg;
   logic [7:0] pkt_cnt_reg;
   logic       rpt_take;
   logic       pkt_full;

   assign rpt_take      = rpt_valid_in && rpt_ready_reg;
   assign pkt_full      = (8'(pkt_cnt_reg + 8'h01) == active_reg.max_packet);
   assign rpt_ready_out = rpt_ready_reg;
   assign pkt_valid_out = pkt_valid_reg;
   assign pkt_data_out  = pkt_data_reg;
   assign pkt_end_out   = pkt_end_reg;

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rpt_ready_reg <= 1'b0;
         pkt_valid_reg <= 1'b0;
         pkt_data_reg  <= '0;
         pkt_end_reg   <= 1'b0;
         pkt_cnt_reg   <= '0;
      end
      else
      begin
         rpt_ready_reg <= !(rpt_take || (pkt_valid_reg && !pkt_ready_in)) && (state_reg != ST_BOOT);
         if (rpt_take)
         begin
            pkt_valid_reg <= 1'b1;
            pkt_data_reg  <= rpt_data_in;
            pkt_end_reg   <= rpt_last_in || pkt_full;
            pkt_cnt_reg   <= (rpt_last_in || pkt_full) ? 8'h00 : 8'(pkt_cnt_reg + 8'h01);
         end
         else if (pkt_ready_in)
         begin
            pkt_valid_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_boot_defaults;
      (state_reg == ST_BOOT) && !nvm_image_in.valid |=> (stored_reg == defaults) && nvm_wr_out;
   endproperty
   a_boot_defaults: assert property (p_boot_defaults) else $error("defaults not loaded");

   property p_desc_frozen;
      (state_reg != ST_BOOT) |=> $stable(desc_cfg_out);
   endproperty
   a_desc_frozen: assert property (p_desc_frozen) else $error("descriptor changed");

   property p_desc_boot;
      (state_reg == ST_BOOT) |=> (desc_cfg_out == stored_reg);
   endproperty
   a_desc_boot: assert property (p_desc_boot) else $error("descriptor not stored value");

   property p_ranges;
      (state_reg != ST_BOOT) && nvm_wr_out |-> (nvm_data_out.interval != 8'h00)
         && (nvm_data_out.max_packet <= `MAX_MAXPKT) && (nvm_data_out.personality <= `MAX_PERSONA);
   endproperty
   a_ranges: assert property (p_ranges) else $error("stored value out of range");

   property p_set_store;
      (state_reg == ST_EXEC) && set_ok |=> nvm_wr_out && (rc_reg == `RC_OK) && (rlen_reg == `LEN_NONE);
   endproperty
   a_set_store: assert property (p_set_store) else $error("set not stored");

   property p_reject;
      (state_reg == ST_EXEC) && !set_ok && !get_ok |=> $stable(stored_reg) && (rc_reg != `RC_OK) && !nvm_wr_out;
   endproperty
   a_reject: assert property (p_reject) else $error("bad request not rejected");

   property p_get_answer;
      (state_reg == ST_EXEC) && get_ok && (sel_reg == `SEL_INTERVAL)
         |=> (rval_reg == stored_reg.interval) && (rlen_reg == `LEN_GET) && (push_data == `RC_OK);
   endproperty
   a_get_answer: assert property (p_get_answer) else $error("get answer wrong");

   property p_pkt_cut;
      rpt_take && !rpt_last_in && pkt_full |=> pkt_valid_out && pkt_end_out;
   endproperty
   a_pkt_cut: assert property (p_pkt_cut) else $error("packet not cut at size");

   property p_pkt_no_short;
      rpt_take && !rpt_last_in && !pkt_full |=> !pkt_end_out;
   endproperty
   a_pkt_no_short: assert property (p_pkt_no_short) else $error("short packet mid-report");

   c_set:    cover property ((state_reg == ST_EXEC) && set_ok);
   c_get:    cover property ((state_reg == ST_EXEC) && get_ok);
   c_reject: cover property ((state_reg == ST_EXEC) && !set_ok && !get_ok);
   c_pkt:    cover property (pkt_valid_out && pkt_end_out && pkt_ready_in);
endmodule

// [nvm_store_model.sv]
// Behavioural non-volatile store that feeds the handler its boot image
`timescale 1ns/1ps
// ****************************************
// Store model
// ****************************************
module nvm_store_model
(
   input  wire logic                                core_clk_in,
   input  wire logic                                wr_in,
   input  wire usb_reader_property_pkg::prop_set_t  data_in,
   output usb_reader_property_pkg::nvm_image_t      image_out
);
   import usb_reader_property_pkg::*;

   // Blank part: junk contents, no valid mark
   nvm_image_t image_reg = {1'b0, 24'h5ac3e1};

   assign image_out = image_reg;

   // Written image survives every reset of the handler
   always @(posedge core_clk_in)
      if (wr_in === 1'b1)
         image_reg <= {1'b1, data_in};
endmodule

// [tb.sv]
// Self-checking bench for the property command handler
`timescale 1ns/1ps
`include "usb_reader_property_map.svh"
module tb;
   import usb_reader_property_pkg::*;
   // ****************************************
   // Signals and bench state
   // ****************************************
   logic       core_clk_in  = 1'b0;
   logic       rst_n_in     = 1'b0;
   logic       cmd_valid_in = 1'b0;
   logic [7:0] cmd_data_in  = 8'h00;
   logic       rsp_ready_in = 1'b0;
   logic       rpt_valid_in = 1'b0;
   logic [7:0] rpt_data_in  = 8'h00;
   logic       rpt_last_in  = 1'b0;
   logic       pkt_ready_in = 1'b0;
   logic       cmd_ready_out, rsp_valid_out, nvm_wr_out, rpt_ready_out, pkt_valid_out, pkt_end_out;
   logic [7:0] rsp_data_out, pkt_data_out;
   nvm_image_t nvm_image_in;
   prop_set_t  nvm_data_out, desc_cfg_out, st, eff;
   prop_set_t  dflt = {`DEF_INTERVAL, `DEF_MAXPKT, `DEF_PERSONA};
   logic [7:0] sels [3] = '{`SEL_INTERVAL, `SEL_MAXPKT, `SEL_PERSONA};
   logic [31:0] bad_tab [10] = '{32'h00000000, 32'h00020200, 32'h01010200, 32'h07020201, 32'h01020200,
                                32'h01020341, 32'h01020300, 32'h01021002, 32'h01020501, 32'h00010500};
   logic [7:0] got_d [$];
   logic       got_e [$];
   logic [7:0] s, v;
   int         seed = 32'hcdf67193;
   int         num_errors = 0;
   int         num_checks = 0;
   int         cycles = 0;
   int         wr_cnt = 0;
   int         wr_exp = 0;
   int unsigned r;

   usb_reader_property_config #(.FIFO_DEPTH(8)) u_dut
   (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_data_in(cmd_data_in),
      .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
      .rsp_ready_in(rsp_ready_in), .nvm_image_in(nvm_image_in), .nvm_wr_out(nvm_wr_out),
      .nvm_data_out(nvm_data_out), .desc_cfg_out(desc_cfg_out), .rpt_valid_in(rpt_valid_in),
      .rpt_data_in(rpt_data_in), .rpt_last_in(rpt_last_in), .rpt_ready_out(rpt_ready_out),
      .pkt_valid_out(pkt_valid_out), .pkt_data_out(pkt_data_out), .pkt_end_out(pkt_end_out),
      .pkt_ready_in(pkt_ready_in)
   );

   nvm_store_model u_nvm
   (
      .core_clk_in(core_clk_in), .wr_in(nvm_wr_out), .data_in(nvm_data_out), .image_out(nvm_image_in)
   );

   // ****************************************
   // Clock, stall pattern, monitors, timeout
   // ****************************************
   always #25 core_clk_in = ~core_clk_in;

   always @(posedge core_clk_in)
   begin
      cycles++;
      pkt_ready_in <= (cycles % 3 != 2);
      if (nvm_wr_out === 1'b1)
         wr_cnt++;
      if (pkt_valid_out === 1'b1 && pkt_ready_in === 1'b1)
      begin
         got_d.push_back(pkt_data_out);
         got_e.push_back(pkt_end_out);
      end
      if (cycles == 20000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ****************************************
   // Expectations
   // ****************************************
   function automatic logic [7:0] exp_rc(input logic [7:0] c, l, s, v);
      logic known;
      known = s inside {`SEL_INTERVAL, `SEL_MAXPKT, `SEL_PERSONA};
      if (c != `CMD_GET && c != `CMD_SET)
         return `RC_BAD_CMD;
      if (c == `CMD_GET)
         return (l == `LEN_GET && known) ? `RC_OK : `RC_BAD_VAL;
      if (l != `LEN_SET || !known)
         return `RC_BAD_VAL;
      if (s == `SEL_INTERVAL)
         return (v >= `MIN_VAL) ? `RC_OK : `RC_BAD_VAL;
      if (s == `SEL_MAXPKT)
         return (v >= `MIN_VAL && v <= `MAX_MAXPKT) ? `RC_OK : `RC_BAD_VAL;
      return (v <= `MAX_PERSONA) ? `RC_OK : `RC_BAD_VAL;
   endfunction

   function automatic logic [7:0] sval(input logic [7:0] s);
      return (s == `SEL_INTERVAL) ? st.interval : (s == `SEL_MAXPKT) ? st.max_packet : st.personality;
   endfunction

   // ****************************************
   // Compare and drive tasks
   // ****************************************
   task automatic chk8(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk24(input prop_set_t got, exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic power_cycle();
      rst_n_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      eff = st;
      chk24(desc_cfg_out, eff);
   endtask

   task automatic put(input logic [7:0] b);
      int n;
      n = 0;
      cmd_valid_in <= 1'b1;
      cmd_data_in  <= b;
      do @(posedge core_clk_in); while (cmd_ready_out !== 1'b1 && ++n < 100);
      if (n >= 100) num_errors++;
   endtask

   task automatic take(output logic [7:0] b);
      int n;
      n = 0;
      rsp_ready_in <= 1'b1;
      do @(posedge core_clk_in); while (rsp_valid_out !== 1'b1 && ++n < 100);
      if (n >= 100) num_errors++;
      b = rsp_data_out;
   endtask

   task automatic txn(input logic [7:0] c, l, s, v);
      logic [7:0] rc, b;
      rc = exp_rc(c, l, s, v);
      put(c);
      put(l);
      if (l > 8'h00) put(s);
      if (l > 8'h01) put(v);
      cmd_valid_in <= 1'b0;
      take(b);
      chk8(b, rc);
      take(b);
      chk8(b, (rc == `RC_OK && c == `CMD_GET) ? `LEN_GET : `LEN_NONE);
      if (rc == `RC_OK && c == `CMD_GET)
      begin
         take(b);
         chk8(b, sval(s));
      end
      rsp_ready_in <= 1'b0;
      if (rc == `RC_OK && c == `CMD_SET)
      begin
         wr_exp++;
         if (s == `SEL_INTERVAL) st.interval = v;
         else if (s == `SEL_MAXPKT) st.max_packet = v;
         else st.personality = v;
      end
      chk24(desc_cfg_out, eff);
      chk24(nvm_data_out, st);
   endtask

   task automatic get_all();
      foreach (sels[i]) txn(`CMD_GET, `LEN_GET, sels[i], 8'h00);
   endtask

   task automatic report(input int len);
      int n, mp;
      mp = int'(eff.max_packet);
      got_d.delete();
      got_e.delete();
      for (int i = 0; i < len; i++)
      begin
         n = 0;
         rpt_valid_in <= 1'b1;
         rpt_data_in  <= 8'(i * 7 + len);
         rpt_last_in  <= (i == len - 1);
         do @(posedge core_clk_in); while (rpt_ready_out !== 1'b1 && ++n < 100);
      end
      rpt_valid_in <= 1'b0;
      rpt_last_in  <= 1'b0;
      n = 0;
      while (got_d.size() < len && n++ < 500) @(posedge core_clk_in);
      chk8(8'(got_d.size()), 8'(len));
      for (int i = 0; i < got_d.size() && i < len; i++)
      begin
         chk8(got_d[i], 8'(i * 7 + len));
         chk8({7'h00, got_e[i]}, {7'h00, ((i + 1) % mp == 0) || (i == len - 1)});
      end
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      st = dflt;
      wr_exp = 1;
      power_cycle();
      get_all();
      foreach (bad_tab[i]) txn(bad_tab[i][31:24], bad_tab[i][23:16], bad_tab[i][15:8], bad_tab[i][7:0]);
      get_all();
      report(5);
      report(16);
      txn(`CMD_SET, `LEN_SET, `SEL_PERSONA, 8'h01);
      power_cycle();
      txn(`CMD_SET, `LEN_SET, `SEL_INTERVAL, 8'hff);
      txn(`CMD_SET, `LEN_SET, `SEL_MAXPKT, 8'h40);
      get_all();
      txn(`CMD_SET, `LEN_SET, `SEL_INTERVAL, 8'h01);
      txn(`CMD_SET, `LEN_SET, `SEL_MAXPKT, 8'h01);
      txn(`CMD_SET, `LEN_SET, `SEL_PERSONA, 8'h00);
      get_all();
      for (int k = 0; k < 16; k++)
      begin
         r = $unsigned($random(seed));
         s = sels[r % 3];
         r = $unsigned($random(seed));
         v = (k % 4 == 3) ? r[15:8] : (s == `SEL_INTERVAL) ? 8'(r % 255 + 1) :
             (s == `SEL_MAXPKT) ? 8'(r % 64 + 1) : 8'(r % 2);
         txn(`CMD_SET, `LEN_SET, s, v);
         txn(`CMD_GET, `LEN_GET, s, 8'h00);
      end
      txn(`CMD_SET, `LEN_SET, `SEL_MAXPKT, 8'h03);
      repeat (5) @(posedge core_clk_in);
      chk8(8'(wr_cnt), 8'(wr_exp));
      power_cycle();
      report(1);
      report(6);
      report(7);
      r = $unsigned($random(seed));
      report(r % 40 + 1);
      repeat (5) @(posedge core_clk_in);
      chk8(8'(wr_cnt), 8'(wr_exp));
      tally_and_finish();
   end
endmodule
